// ==== verilog/scd_pkg.sv ====
/*
  Constants and types for the sample-clock divider, its sync realignment,
  the duty cycle restorer and the reference select logic.
  Assumes a single 100 MHz clock that stands for the input sample clock.
*/
`default_nettype none

package scd_pkg;

  // Clock and duty cycle restorer timing
  localparam int unsigned CLK_FREQ_MHZ   = 100;
  localparam int unsigned DCR_MIN_MHZ    = 20;
  localparam int unsigned DCR_LOCK_NS    = 1500;
  localparam int unsigned DCR_LOCK_CYC   =
    (DCR_LOCK_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam bit          DCR_RATE_OK    = (CLK_FREQ_MHZ >= DCR_MIN_MHZ);

  // Divider limits
  localparam logic [2:0]  DIV_MIN        = 3'h1;
  localparam logic [2:0]  DIV_MAX        = 3'h6;

  // Register byte addresses
  localparam logic [11:0] ADDR_SYNC_CTL  = 12'h100;
  localparam logic [11:0] ADDR_DIV_CTL   = 12'h104;
  localparam logic [11:0] ADDR_STATUS    = 12'h108;

  // Field positions
  localparam int unsigned SYNC_EN_BIT    = 1;
  localparam int unsigned SYNC_ONCE_BIT  = 2;
  localparam int unsigned DIV_RATIO_LSB  = 0;
  localparam int unsigned DIV_DCR_BIT    = 3;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic       restorer_en;
    logic [2:0] ratio;
  } scd_div_cfg_t;

  typedef struct packed {
    logic first_only;
    logic enable;
  } scd_sync_cfg_t;

  localparam scd_div_cfg_t  DIV_CFG_RST  = '{restorer_en: 1'b1,
                                             ratio: 3'h1};
  localparam scd_sync_cfg_t SYNC_CFG_RST = '{first_only: 1'b0,
                                             enable: 1'b0};

  typedef enum logic [1:0] {
    SYNC_OFF,
    SYNC_EVERY,
    SYNC_ARMED,
    SYNC_DONE
  } scd_sync_state_t;

endpackage

`default_nettype wire

// ==== verilog/scd_sample_clock.sv ====
/*
  Sample-clock conditioning: integer divider with sync realignment, duty
  cycle restorer, configured over AXI4-Lite, and a reference select driven by the sense pins.
  Assumes aclk is the incoming sample clock; sync and sense pins are async.
*/
// Chosen here: the register addresses and register access over AXI4-Lite.
// What this block does
// - Divide the sample clock by any integer ratio from one to six.
// - Two-bit field picks realign on every sync or first sync after write.
// - An accepted sync pulse returns the divider counter to its start state.
// - Restorer on regenerates the falling edge for a half-period high time.
// - Below the minimum clock rate the restorer gives no duty correction.
// - Sense pin near ground selects the internal one-volt reference.
// - Sense pin at analog supply level selects the external reference.
// - Each sample is taken on the rising edge of the divided clock.
`default_nettype none

module scd_sample_clock
  import scd_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  input  wire logic        sync_pin,
  input  wire logic        sense_near_ground,
  input  wire logic        sense_at_analog_supply_level,
  // Conditioned clock and reference select
  output logic             conv_clk,
  output logic             sample_strobe,
  output logic             int_ref_en,
  output logic             ext_ref_sel
);
  import scd_pkg::*;

  // Bus slave state
  logic            aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [11:0]     aw_addr_q;
  logic [31:0]     w_data_q, rdata_q;
  logic [3:0]      w_strb_q;
  logic [1:0]      bresp_q, rresp_q;
  logic            wr_go;
  logic            sync_wr_w, div_wr_w;

  // Configuration and block state
  scd_div_cfg_t    div_cfg_q;
  scd_sync_cfg_t   sync_cfg_q;
  scd_sync_state_t sync_st_q, sync_st_d;
  logic [2:0]      cnt_q, cnt_d, high_w;
  logic            conv_clk_q, strobe_q;
  logic [7:0]      lock_cnt_q;
  logic            dcr_locked_q, dcr_active_w;
  logic [2:0]      sync_sr_q, gnd_sr_q, sup_sr_q;
  logic            sync_take_w;
  logic            int_ref_q, ext_ref_q;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go         = aw_hold_q && w_hold_q && !bvalid_q;
  assign sync_wr_w     = wr_go && aw_addr_q == ADDR_SYNC_CTL && w_strb_q[0];
  assign div_wr_w      = wr_go && aw_addr_q == ADDR_DIV_CTL && w_strb_q[0];

  // Address and data may arrive in either order; the write lands once both
  // are held, so the response comes one edge after the later of the two.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (aw_addr_q == ADDR_SYNC_CTL ||
                      aw_addr_q == ADDR_DIV_CTL) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_SYNC_CTL: rdata_q <= {29'h0, sync_cfg_q, 1'b0};
        ADDR_DIV_CTL:  rdata_q <= {28'h0, div_cfg_q};
        ADDR_STATUS:   rdata_q <= {26'h0, sync_st_q == SYNC_DONE,
                                   sync_st_q == SYNC_ARMED, ext_ref_q,
                                   int_ref_q, dcr_active_w, dcr_locked_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // An out-of-range ratio is dropped and the previous ratio kept, so the
  // divider never sees zero or seven.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cfg_q  <= DIV_CFG_RST;
      sync_cfg_q <= SYNC_CFG_RST;
    end else begin
      if (div_wr_w) begin
        div_cfg_q.restorer_en <= w_data_q[DIV_DCR_BIT];
        if (w_data_q[DIV_RATIO_LSB +: 3] >= DIV_MIN &&
            w_data_q[DIV_RATIO_LSB +: 3] <= DIV_MAX)
          div_cfg_q.ratio <= w_data_q[DIV_RATIO_LSB +: 3];
      end
      if (sync_wr_w) begin
        sync_cfg_q.enable     <= w_data_q[SYNC_EN_BIT];
        sync_cfg_q.first_only <= w_data_q[SYNC_ONCE_BIT];
      end
    end
  end

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_sr_q <= 3'h0;
      gnd_sr_q  <= 3'h0;
      sup_sr_q  <= 3'h0;
    end else begin
      sync_sr_q <= {sync_sr_q[1:0], sync_pin};
      gnd_sr_q  <= {gnd_sr_q[1:0], sense_near_ground};
      sup_sr_q  <= {sup_sr_q[1:0], sense_at_analog_supply_level};
    end
  end

  // A sync pulse counts once, on its rising edge
  assign sync_take_w = sync_sr_q[1] && !sync_sr_q[2] &&
                       (sync_st_q == SYNC_EVERY ||
                        sync_st_q == SYNC_ARMED);

  // Writing the field re-arms one-shot mode even if a pulse lands together
  always_comb begin
    sync_st_d = sync_st_q;
    if (sync_wr_w) begin
      if (!w_data_q[SYNC_EN_BIT])
        sync_st_d = SYNC_OFF;
      else if (w_data_q[SYNC_ONCE_BIT])
        sync_st_d = SYNC_ARMED;
      else
        sync_st_d = SYNC_EVERY;
    end else begin
      unique case (sync_st_q)
        SYNC_OFF:   sync_st_d = SYNC_OFF;
        SYNC_EVERY: sync_st_d = SYNC_EVERY;
        SYNC_ARMED: sync_st_d = sync_take_w ? SYNC_DONE : SYNC_ARMED;
        SYNC_DONE:  sync_st_d = SYNC_DONE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      sync_st_q <= SYNC_OFF;
    else
      sync_st_q <= sync_st_d;
  end

  // Any divider write with byte 0 enabled restarts the lock count, so the loop relocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_q   <= 8'h00;
      dcr_locked_q <= 1'b0;
    end else if (div_wr_w || !div_cfg_q.restorer_en || !DCR_RATE_OK) begin
      lock_cnt_q   <= 8'h00;
      dcr_locked_q <= 1'b0;
    end else if (lock_cnt_q == 8'(DCR_LOCK_CYC - 1)) begin
      dcr_locked_q <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
    end
  end

  // Software is expected to enable the restorer for ratios 2 to 6;
  // without it the output high time is a single input period.
  assign dcr_active_w = div_cfg_q.restorer_en && dcr_locked_q &&
                        DCR_RATE_OK && div_cfg_q.ratio >= 3'h2;
  assign high_w       = dcr_active_w ? (div_cfg_q.ratio >> 1) : 3'h1;

  // Count 0 is the initial state and carries the sampling edge
  always_comb begin
    if (sync_take_w)
      cnt_d = 3'h0;
    else if (cnt_q >= div_cfg_q.ratio - 3'h1)
      cnt_d = 3'h0;
    else
      cnt_d = cnt_q + 3'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q      <= 3'h0;
      conv_clk_q <= 1'b0;
      strobe_q   <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      conv_clk_q <= cnt_d < high_w;
      strobe_q   <= cnt_d == 3'h0;
    end
  end

  // A sense level between the two bands keeps the previous choice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ref_q <= 1'b1;
      ext_ref_q <= 1'b0;
    end else if (sup_sr_q[2]) begin
      int_ref_q <= 1'b0;
      ext_ref_q <= 1'b1;
    end else if (gnd_sr_q[2]) begin
      int_ref_q <= 1'b1;
      ext_ref_q <= 1'b0;
    end
  end

  assign conv_clk      = conv_clk_q;
  assign sample_strobe = strobe_q;
  assign int_ref_en    = int_ref_q;
  assign ext_ref_sel   = ext_ref_q;

  // Helper: cycles since the last strobe, and whether it was disturbed
  logic [2:0] gap_q;
  logic       disturb_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q     <= 3'h0;
      disturb_q <= 1'b1;
    end else begin
      gap_q     <= strobe_q ? 3'h1 : gap_q + 3'h1;
      disturb_q <= sync_take_w || div_wr_w || (disturb_q && !strobe_q);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_quiet;
    !sync_take_w && !div_wr_w;
  endsequence

  sequence s_rise4;
    $rose(conv_clk_q) && dcr_active_w && div_cfg_q.ratio == 3'h4;
  endsequence

  a_ratio_range: assert property (
    div_cfg_q.ratio >= DIV_MIN && div_cfg_q.ratio <= DIV_MAX)
    else $error("divide ratio out of range");
  a_sync_realign: assert property (
    sync_take_w |=> cnt_q == 3'h0 && strobe_q)
    else $error("sync did not reset the divider");
  a_one_shot_disarm: assert property (
    sync_take_w && sync_st_q == SYNC_ARMED && !sync_wr_w
    |=> sync_st_q == SYNC_DONE ##1 !sync_take_w)
    else $error("one-shot sync not disarmed");
  a_every_stays: assert property (
    sync_take_w && sync_st_q == SYNC_EVERY && !sync_wr_w
    |=> sync_st_q == SYNC_EVERY)
    else $error("every-pulse sync mode lost");
  a_strobe_spacing: assert property (
    strobe_q && !disturb_q && $stable(div_cfg_q.ratio)
    |-> gap_q == div_cfg_q.ratio)
    else $error("strobe spacing differs from ratio");
  a_strobe_on_rise: assert property (
    $rose(conv_clk_q) |-> strobe_q)
    else $error("sample strobe missed the rising edge");
  a_restorer_half: assert property (
    (s_rise4 ##0 s_quiet) ##1 s_quiet |-> conv_clk_q ##1 !conv_clk_q)
    else $error("restored high time is not half a period");
  a_restorer_off: assert property (
    $rose(conv_clk_q) && !dcr_active_w && div_cfg_q.ratio > 3'h1 &&
    !sync_take_w && !div_wr_w |=> !conv_clk_q)
    else $error("unrestored high time is not one period");
  a_slow_no_fix: assert property (
    !(DCR_RATE_OK && dcr_locked_q) |-> high_w == 3'h1)
    else $error("duty corrected while slow or unlocked");
  a_ref_internal: assert property (
    gnd_sr_q[2] && !sup_sr_q[2] |=> int_ref_q && !ext_ref_q)
    else $error("internal reference not selected");
  a_ref_external: assert property (
    sup_sr_q[2] |=> ext_ref_q && !int_ref_q)
    else $error("external reference not selected");

endmodule

`default_nettype wire

// ==== tb/scd_sync_src.sv ====
/*
  Far-side model of scd_sample_clock: sync pulse generator and the
  reference sense comparator levels.
  Assumes its tasks are called from a process that follows aclk.
*/
`default_nettype none

module scd_sync_src (
  // Clock
  input  wire logic aclk,
  // Pins
  output var  logic sync_pin,
  output var  logic sense_near_ground,
  output var  logic sense_at_analog_supply_level
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sync_pin = 1'b0;
    sense_near_ground = 1'b1;
    sense_at_analog_supply_level = 1'b0;
  end

  // Two cycles high, then rest low so a following pulse counts again
  task automatic send_pulse();
    @(posedge aclk);
    sync_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    sync_pin <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic set_sense(input logic g, input logic s);
    @(posedge aclk);
    sense_near_ground <= g;
    sense_at_analog_supply_level <= s;
  endtask
endmodule

`default_nettype wire

// ==== tb/scd_sample_clock_bench.sv ====
/*
  Self-checking bench for scd_sample_clock: registers, divider, sync modes
  and reference select.
  Assumes scd_sync_src drives the pins; aclk is made here at 100 MHz.
*/
`default_nettype none

module scd_sample_clock_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import scd_pkg::*;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, sync_pin, gnd;
  logic        sup, conv_clk, strobe, int_ref, ext_ref;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, num_checks, cyc, r;

  scd_sample_clock dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sync_pin(sync_pin), .sense_near_ground(gnd),
    .sense_at_analog_supply_level(sup), .conv_clk(conv_clk),
    .sample_strobe(strobe), .int_ref_en(int_ref), .ext_ref_sel(ext_ref));

  scd_sync_src u_src (.aclk(aclk), .sync_pin(sync_pin),
    .sense_near_ground(gnd), .sense_at_analog_supply_level(sup));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short; the full run needs about 1200 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Waits for the response; only the bench timeout ends a hang
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, m,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", e, rdata & m);
  endtask

  task automatic wait_strobe();
    int k;
    k = 0;
    do begin
      @(posedge aclk);
      #1;
      k++;
    end while (!strobe && k < 20);
  endtask

  // Period in cycles between strobes and conv_clk high cycles within it
  task automatic measure(input int pe, he);
    int p, h;
    wait_strobe();
    p = 0;
    h = 0;
    do begin
      if (conv_clk) h++;
      p++;
      @(posedge aclk);
      #1;
    end while (!strobe && p < 10);
    chk("period", pe, p);
    chk("high", he, h);
  endtask

  // Pulse starts one edge after a strobe; ratio 6 gives 6 if ignored
  task automatic sync_chk(input int e);
    int n;
    wait_strobe();
    fork
      u_src.send_pulse();
      begin
        n = 0;
        do begin
          @(posedge aclk);
          #1;
          n++;
        end while (!strobe && n < 8);
      end
    join
    chk("sync latency", e, n);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {failures, num_checks, cyc} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("conv_clk", 1, conv_clk);
    chk("int_ref", 1, int_ref);
    rd(ADDR_DIV_CTL, 32'h9, 32'hf, RESP_OKAY);
    rd(ADDR_SYNC_CTL, 32'h0, 32'h6, RESP_OKAY);
    rd(12'h10c, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
    // Byte 0 not enabled: the write is answered but changes nothing
    wstrb <= 4'he;
    wr(ADDR_DIV_CTL, 32'h5, RESP_OKAY);
    wstrb <= 4'hf;
    rd(ADDR_DIV_CTL, 32'h9, 32'hf, RESP_OKAY);
    for (r = 1; r <= 6; r++) begin
      wr(ADDR_DIV_CTL, 32'h8 | r, RESP_OKAY);
      repeat (DCR_LOCK_CYC + 5) @(posedge aclk);
      rd(ADDR_STATUS, {28'h0, 2'b01, r > 1, 1'b1}, 32'hf, RESP_OKAY);
      measure(r, r > 1 ? r / 2 : 1);
    end
    wr(ADDR_DIV_CTL, 32'h4, RESP_OKAY);
    measure(4, 1);
    wr(ADDR_DIV_CTL, 32'h7, RESP_OKAY);
    measure(4, 1);
    wr(ADDR_DIV_CTL, 32'he, RESP_OKAY);
    wr(ADDR_SYNC_CTL, 32'h2, RESP_OKAY);
    sync_chk(4);
    sync_chk(4);
    wr(ADDR_SYNC_CTL, 32'h6, RESP_OKAY);
    rd(ADDR_SYNC_CTL, 32'h6, 32'h6, RESP_OKAY);
    rd(ADDR_STATUS, 32'h10, 32'h30, RESP_OKAY);
    sync_chk(4);
    rd(ADDR_STATUS, 32'h20, 32'h30, RESP_OKAY);
    sync_chk(6);
    wr(ADDR_SYNC_CTL, 32'h6, RESP_OKAY);
    rd(ADDR_STATUS, 32'h10, 32'h30, RESP_OKAY);
    sync_chk(4);
    wr(ADDR_SYNC_CTL, 32'h0, RESP_OKAY);
    sync_chk(6);
    u_src.set_sense(1'b0, 1'b1);
    repeat (4) @(posedge aclk);
    #1;
    chk("ref", 2'b01, {int_ref, ext_ref});
    rd(ADDR_STATUS, 32'h8, 32'hc, RESP_OKAY);
    u_src.set_sense(1'b1, 1'b0);
    repeat (4) @(posedge aclk);
    #1;
    chk("ref", 2'b10, {int_ref, ext_ref});
    rd(ADDR_STATUS, 32'h4, 32'hc, RESP_OKAY);
    give_verdict();
  end
endmodule

`default_nettype wire
